// ---- verilog/uts_responder.sv ----
// Purpose: Under-temperature fault response sequencer with its command registers.
// Assumes: Fault level comes from a comparator; on/off requests are synchronous.
// Notes:   A restart attempt enables the output and checks the fault one cycle later.
`timescale 1ns/10ps
module uts_responder
#(
  parameter int UNIT_BASE_CYC = uts_pkg::UNIT_BASE_CYC
)
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire uts_pkg::uts_cmd_s i_cmd,
  input  wire logic             i_ut_fault,
  input  wire logic             i_ctrl_on,
  input  wire logic             i_op_on,
  output logic [7:0]            o_rdata,
  output logic                  o_rvalid,
  output logic                  o_nack,
  output logic                  o_output_en,
  output logic                  o_fault_flag
);
  import uts_pkg::*;

  logic       rst_n;
  logic [7:0] cfg_q;
  logic [7:0] unit_q;
  logic       flag_q;
  logic       cmd_on;
  logic       cmd_on_q;
  logic       off_on;
  logic       wr;
  logic       rd;
  logic       clr_all;
  logic       clr_bit;
  logic       clr_evt;
  logic       known;
  logic [2:0] tries_q;
  logic       t_start;
  logic       t_done;
  logic       fail;
  logic       give_up;
  uts_resp_e  resp;
  logic [2:0] retry;
  logic [2:0] dcode;
  uts_state_e state_q;
  uts_state_e state_d;

  // ----------------------------------------------------------------------
  // Reset release and delay timer
  // ----------------------------------------------------------------------
  uts_rst_sync u_rst
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_rst_n (rst_n)
  );

  uts_delay_timer #(.BASE_CYC(UNIT_BASE_CYC)) u_timer
  (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_start (t_start),
    .i_code  (dcode),
    .i_unit  (unit_q),
    .o_done  (t_done)
  );

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Field views of the configuration byte and the clearing events.
  assign resp    = uts_resp_e'(cfg_q[RESP_HI:RESP_LO]);
  assign retry   = cfg_q[RETRY_HI:RETRY_LO];
  assign dcode   = cfg_q[DELAY_HI:DELAY_LO];
  assign wr      = i_cmd.valid & i_cmd.write;
  assign rd      = i_cmd.valid & ~i_cmd.write;
  assign clr_all = wr & (i_cmd.code == CODE_CLEAR_ALL);
  assign clr_bit = wr & (i_cmd.code == CODE_STATUS) & i_cmd.data[STAT_UT_BIT];
  assign cmd_on  = i_ctrl_on & i_op_on;
  assign off_on  = cmd_on & ~cmd_on_q;
  assign clr_evt = clr_all | clr_bit | off_on;
  assign known   = (i_cmd.code == CODE_UT_RESP) | (i_cmd.code == CODE_DELAY_UNIT)
                 | (i_cmd.code == CODE_STATUS) | (i_cmd.code == CODE_CLEAR_ALL);

  // Configuration byte; byte writes at the response code.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_q <= CFG_RST;
    else if (wr && i_cmd.code == CODE_UT_RESP)
      cfg_q <= i_cmd.data;
  end

  // Delay unit length register.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      unit_q <= UNIT_RST;
    else if (wr && i_cmd.code == CODE_DELAY_UNIT)
      unit_q <= i_cmd.data;
  end

  // Read answers one cycle after the request; unknown codes are refused.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_rdata  <= BYTE_ZERO;
      o_rvalid <= 1'b0;
      o_nack   <= 1'b0;
    end
    else
    begin
      o_rvalid <= rd & known;
      o_nack   <= i_cmd.valid & ~known;
      if (rd)
      begin
        unique case (i_cmd.code)
          CODE_UT_RESP:    o_rdata <= cfg_q;
          CODE_DELAY_UNIT: o_rdata <= unit_q;
          CODE_STATUS:     o_rdata <= BYTE_ZERO | (8'(flag_q) << STAT_UT_BIT);
          default:         o_rdata <= BYTE_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sticky flag and on/off history
  // ----------------------------------------------------------------------
  // A fault in the clearing cycle wins, so no detection is lost.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else if (i_ut_fault)
      flag_q <= 1'b1;
    else if (clr_evt)
      flag_q <= 1'b0;
  end

  // Previous on request, for spotting an off-then-on sequence.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_on_q <= 1'b0;
    else
      cmd_on_q <= cmd_on;
  end

  assign o_fault_flag = flag_q;

  // ----------------------------------------------------------------------
  // Response sequencer
  // ----------------------------------------------------------------------
  // A failed attempt gives up once the programmed count is spent.
  assign fail    = (state_q == ST_ATTEMPT) & i_ut_fault;
  assign give_up = (retry != RETRY_FOREVER) & ((tries_q + 3'h1) >= retry);

  always_comb
  begin
    state_d = state_q;
    t_start = 1'b0;
    if (!cmd_on || clr_evt)
    begin
      state_d = ST_RUN;
    end
    else
    begin
      unique case (state_q)
        ST_RUN:
        begin
          if (i_ut_fault)
          begin
            unique case (resp)
              RESP_IGNORE:  state_d = ST_RUN;
              RESP_DELAY:
              begin
                state_d = ST_DELAY;
                t_start = 1'b1;
              end
              RESP_DISABLE:
              begin
                state_d = (retry == RETRY_NONE) ? ST_LATCHED : ST_WAIT;
                t_start = 1'b1;
              end
              RESP_LATCH:   state_d = ST_LATCHED;
            endcase
          end
        end
        ST_DELAY:
        begin
          if (t_done && !i_ut_fault)
            state_d = ST_RUN;
          else if (t_done)
          begin
            state_d = (retry == RETRY_NONE) ? ST_LATCHED : ST_WAIT;
            t_start = 1'b1;
          end
        end
        ST_WAIT:
        begin
          if (t_done)
          begin
            state_d = ST_ATTEMPT;
            t_start = 1'b1;
          end
        end
        ST_ATTEMPT:
        begin
          if (!i_ut_fault)
            state_d = ST_RUN;
          else if (give_up)
            state_d = ST_LATCHED;
          else
            state_d = ST_WAIT;
        end
        ST_LATCHED: state_d = ST_LATCHED;
        default:    state_d = ST_LATCHED;
      endcase
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_RUN;
    else
      state_q <= state_d;
  end

  // Failed attempts so far; the count is dropped whenever the loop ends.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      tries_q <= 3'h0;
    else if (state_d == ST_RUN || state_d == ST_LATCHED)
      tries_q <= 3'h0;
    else if (fail && retry != RETRY_FOREVER)
      tries_q <= tries_q + 3'h1;
  end

  // Output power is allowed only in the running states and when commanded on.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_output_en <= 1'b0;
    else
      o_output_en <= cmd_on & ((state_d == ST_RUN) | (state_d == ST_DELAY)
                     | (state_d == ST_ATTEMPT));
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence s_quiet;
    cmd_on && !clr_evt;
  endsequence

  sequence s_fail_attempt;
    state_q == ST_ATTEMPT && i_ut_fault && cmd_on && !clr_evt;
  endsequence

  cfg_write_a: assert property (wr && i_cmd.code == CODE_UT_RESP
    |=> cfg_q == $past(i_cmd.data)) else $error("config byte not stored");

  ignore_run_a: assert property (state_q == ST_RUN && resp == RESP_IGNORE
    && !wr ##0 s_quiet |=> state_q == ST_RUN && o_output_en)
    else $error("ignore response left run state");

  delay_on_a: assert property (state_q == ST_RUN && i_ut_fault
    && resp == RESP_DELAY && !wr ##0 s_quiet |=> state_q == ST_DELAY && o_output_en)
    else $error("delay response did not keep output on");

  disable_now_a: assert property (state_q == ST_RUN && i_ut_fault
    && resp == RESP_DISABLE ##0 s_quiet |=> !o_output_en)
    else $error("disable response left output on");

  latch_hold_a: assert property (state_q == ST_LATCHED ##0 s_quiet
    |=> state_q == ST_LATCHED && !o_output_en) else $error("latched off released early");

  clear_flag_a: assert property (clr_evt && !i_ut_fault
    |=> !flag_q) else $error("fault flag not cleared");

  off_on_a: assert property (!cmd_on ##1 cmd_on
    |=> state_q == ST_RUN) else $error("off then on did not clear");

  no_retry_a: assert property (state_q == ST_DELAY && t_done && i_ut_fault
    && retry == RETRY_NONE && !wr ##0 s_quiet |=> state_q == ST_LATCHED)
    else $error("zero retry setting did not latch off");

  retry_limit_a: assert property (s_fail_attempt ##0 give_up && !wr
    |=> state_q == ST_LATCHED) else $error("retry limit not honoured");

  attempt_space_a: assert property (state_q == ST_WAIT ##1 state_q == ST_ATTEMPT
    |-> $past(t_done)) else $error("attempt started before delay");

  retry_forever_a: assert property (s_fail_attempt ##0 retry == RETRY_FOREVER
    && !wr |=> state_q == ST_WAIT) else $error("continuous retry stopped");

  flag_set_a: assert property (i_ut_fault
    |=> flag_q [*2] or (flag_q ##1 1'b1)) else $error("fault flag not set");

endmodule

// ---- inc/uts_pkg.sv ----
// Purpose: Shared constants and types for the under-temperature fault responder.
// Assumes: A byte-wide command port fed by the device's PMBus command layer.
// Notes:   Command codes, field positions and reset values live here only.
package uts_pkg;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CODE_UT_RESP    = 8'h54;
  localparam logic [7:0] CODE_DELAY_UNIT = 8'hD2;
  localparam logic [7:0] CODE_STATUS     = 8'h7D;
  localparam logic [7:0] CODE_CLEAR_ALL  = 8'h03;

  // ----------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------
  localparam int         RESP_HI       = 7;
  localparam int         RESP_LO       = 6;
  localparam int         RETRY_HI      = 5;
  localparam int         RETRY_LO      = 3;
  localparam int         DELAY_HI      = 2;
  localparam int         DELAY_LO      = 0;
  localparam int         STAT_UT_BIT   = 4;
  localparam logic [7:0] CFG_RST       = 8'h80;
  localparam logic [7:0] UNIT_RST      = 8'h00;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ----------------------------------------------------------------------
  // Timing: one base tick of the delay unit register
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int UNIT_BASE_NS  = 1000;
  localparam int UNIT_BASE_CYC = UNIT_BASE_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RESP_IGNORE  = 2'h0,
    RESP_DELAY   = 2'h1,
    RESP_DISABLE = 2'h2,
    RESP_LATCH   = 2'h3
  } uts_resp_e;

  // Gray codes along run, delay, wait, attempt, then latched off.
  typedef enum logic [2:0] {
    ST_RUN     = 3'h0,
    ST_DELAY   = 3'h1,
    ST_WAIT    = 3'h3,
    ST_ATTEMPT = 3'h2,
    ST_LATCHED = 3'h6
  } uts_state_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [7:0] data;
  } uts_cmd_s;

  // Delay field decode: two to the power of the code, 1 up to 128 units.
  function automatic logic [15:0] units_of(input logic [2:0] code);
    units_of = 16'h0001 << code;
  endfunction

endpackage

// ---- verilog/uts_rst_sync.sv ----
// Purpose: Two-stage release synchroniser for the active-low reset.
// Assumes: Reset asserts asynchronously at any time.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/10ps
module uts_rst_sync
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  output logic      o_rst_n
);
  import uts_pkg::*;

  logic meta_q;
  logic sync_q;

  // Assertion is immediate; release waits two edges to avoid metastability.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= 1'b1;
      sync_q <= meta_q;
    end
  end

  assign o_rst_n = sync_q;

endmodule

// ---- verilog/uts_delay_timer.sv ----
// Purpose: Counts a delay of 2^code units, each unit (unit_reg + 1) base ticks.
// Assumes: A start pulse reloads the timer even while it is running.
// Notes:   o_done is a one-cycle pulse after the full delay has elapsed.
`timescale 1ns/10ps
module uts_delay_timer
#(
  parameter int BASE_CYC = uts_pkg::UNIT_BASE_CYC
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  wire logic [2:0] i_code,
  input  wire logic [7:0] i_unit,
  output logic            o_done
);
  import uts_pkg::*;

  localparam logic [15:0] BASE_LAST = 16'(BASE_CYC - 1);

  logic [15:0] units_q;
  logic [15:0] base_q;
  logic        busy_q;
  logic [15:0] total;

  // Total delay in ticks; the largest value, 128 * 256, fits in 16 bits.
  assign total = units_of(i_code) * (16'(i_unit) + 16'h0001);

  // ----------------------------------------------------------------------
  // Tick and unit counters
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      units_q <= 16'h0000;
      base_q  <= 16'h0000;
      busy_q  <= 1'b0;
      o_done  <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        units_q <= total;
        base_q  <= BASE_LAST;
        busy_q  <= 1'b1;
      end
      else if (busy_q)
      begin
        if (base_q == 16'h0000)
        begin
          base_q <= BASE_LAST;
          if (units_q == 16'h0001)
          begin
            busy_q <= 1'b0;
            o_done <= 1'b1;
          end
          else
          begin
            units_q <= units_q - 16'h0001;
          end
        end
        else
        begin
          base_q <= base_q - 16'h0001;
        end
      end
    end
  end

endmodule

// ---- testbench/uts_host_model.sv ----
// Purpose: Behavioural command host for the fault responder.
// Assumes: One request per call, launched 1 ns after a rising edge.
// Notes:   Idle command fields show the inverse of the last request.
`timescale 1ns/10ps
module uts_host_model
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  input  wire logic       i_nack,
  output uts_pkg::uts_cmd_s o_cmd,
  output logic            o_ctrl_on,
  output logic            o_op_on
);
  import uts_pkg::*;

  // --------------------------------------------------------------------
  // Idle state
  // --------------------------------------------------------------------
  // Output is commanded on from time zero so the converter starts.
  initial
  begin
    o_cmd     = '0;
    o_ctrl_on = 1'b1;
    o_op_on   = 1'b1;
  end

  // --------------------------------------------------------------------
  // Transfers
  // --------------------------------------------------------------------
  // One byte request; the answer is taken one edge after the request.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data,
                      output logic [7:0] rdata, output logic ack, output logic nack);
    @(posedge i_clk);
    #1;
    o_cmd = '{valid: 1'b1, write: wr, code: code, data: data};
    @(posedge i_clk);
    #1;
    // Released fields must not look like a held request.
    o_cmd = '{valid: 1'b0, write: ~wr, code: ~code, data: ~data};
    rdata = i_rdata;
    ack   = i_rvalid;
    nack  = i_nack;
  endtask

  // Byte write; status clear and clear-all travel this way too.
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    logic [7:0] d;
    logic       a;
    logic       k;
    xfer(1'b1, code, data, d, a, k);
  endtask

  // Control pin and operation command levels.
  task automatic power(input logic ctrl, input logic op);
    @(posedge i_clk);
    #1;
    o_ctrl_on = ctrl;
    o_op_on   = op;
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the under-temperature fault responder.
// Assumes: Base tick shortened to 2 cycles; inputs move 1 ns after edges.
// Notes:   Output enable is watched directly for attempts and spacing.
`timescale 1ns/10ps
module testbench;
  import uts_pkg::*;

  localparam int BASE = 2;

  logic       i_clk;
  logic       i_rst_n;
  logic       i_ut_fault;
  uts_cmd_s   cmd;
  logic [7:0] rdata;
  logic       rvalid;
  logic       nack;
  logic       out_en;
  logic       flag;
  logic       ctrl_on;
  logic       op_on;
  int         n_errors;
  int         num_checks;
  int         n;
  int         gap;
  logic [7:0] d;
  logic       a;
  logic       k;

  // --------------------------------------------------------------------
  // Clock, design and host
  // --------------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  uts_responder #(.UNIT_BASE_CYC(BASE)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd(cmd), .i_ut_fault(i_ut_fault),
    .i_ctrl_on(ctrl_on), .i_op_on(op_on), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_nack(nack), .o_output_en(out_en), .o_fault_flag(flag));

  uts_host_model host (
    .i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .i_nack(nack),
    .o_cmd(cmd), .o_ctrl_on(ctrl_on), .o_op_on(op_on));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask

  // Bounded wait for the enable to reach a level; a hang ends the run.
  task automatic wait_out(input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while (out_en !== lvl)
    begin
      if (cnt == bound)
      begin
        n_errors++;
        $display("ERROR t=%0t timeout seen=%h exp=%h", $time, out_en, lvl);
        finish_test;
      end
      step(1);
      cnt++;
    end
  endtask

  // Counts enable rises over a window and the gap between the first two.
  task automatic count_rises(input int win, output int cnt, output int g);
    int   last;
    logic prev;
    cnt  = 0;
    g    = 0;
    last = 0;
    prev = out_en;
    for (int i = 1; i <= win; i++)
    begin
      step(1);
      if (out_en === 1'b1 && prev !== 1'b1)
      begin
        cnt++;
        if (cnt == 2)
          g = i - last;
        last = i;
      end
      prev = out_en;
    end
  endtask

  task automatic rd_check(input logic [7:0] code, input logic [7:0] exp);
    host.xfer(1'b0, code, 8'h00, d, a, k);
    check({7'h00, a, d}, {8'h01, exp});
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    n_errors   = 0;
    num_checks = 0;
    i_rst_n    = 1'b0;
    i_ut_fault = 1'b0;
    step(10);
    i_rst_n = 1'b1;
    step(5);

    // Reset values, round trip and an unmapped code.
    rd_check(CODE_UT_RESP, CFG_RST);
    rd_check(CODE_DELAY_UNIT, UNIT_RST);
    rd_check(CODE_STATUS, BYTE_ZERO);
    host.xfer(1'b0, 8'h55, 8'h00, d, a, k);
    check({a, k}, 2'b01);
    host.wr(CODE_UT_RESP, 8'h5A);
    rd_check(CODE_UT_RESP, 8'h5A);
    $display("test registers done");

    // Ignore response: output keeps running, flag is sticky.
    host.wr(CODE_UT_RESP, 8'h00);
    i_ut_fault = 1'b1;
    step(20);
    check(out_en, 1'b1);
    i_ut_fault = 1'b0;
    step(3);
    check(flag, 1'b1);
    rd_check(CODE_STATUS, 8'h10);
    host.wr(CODE_STATUS, 8'h10);
    step(1);
    check(flag, 1'b0);
    $display("test ignore done");

    // Latch-off response released by clear-all and by off-then-on of each on input.
    host.wr(CODE_UT_RESP, 8'hC0);
    for (int e = 0; e < 3; e++)
    begin
      i_ut_fault = 1'b1;
      step(2);
      i_ut_fault = 1'b0;
      step(10);
      check(out_en, 1'b0);
      if (e == 0)
        host.wr(CODE_CLEAR_ALL, 8'h00);
      else
      begin
        host.power(e == 2, e == 1);
        host.power(1'b1, 1'b1);
      end
      wait_out(1'b1, 6, n);
      check(flag, 1'b0);
    end
    $display("test latch done");

    // Disable and retry: every retry code, attempt count and spacing.
    for (int r = 0; r < 8; r++)
    begin
      host.wr(CODE_UT_RESP, {2'b10, 3'(r), 3'(r % 3)});
      i_ut_fault = 1'b1;
      count_rises(130, n, gap);
      if (r == 7)
        check(n > 6, 1'b1);
      else
        check(16'(n), 16'(r));
      if (r >= 2)
        check(16'(gap), 16'((1 << (r % 3)) * BASE + 1));
      if (r == 7)
      begin
        host.power(1'b0, 1'b1);
        step(1);
        check(out_en, 1'b0);
        i_ut_fault = 1'b0;
        host.power(1'b1, 1'b1);
      end
      else
      begin
        i_ut_fault = 1'b0;
        host.wr(CODE_CLEAR_ALL, 8'h00);
      end
      wait_out(1'b1, 10, n);
    end
    $display("test retry done");

    // Delay response with a longer unit, no retry afterwards.
    host.wr(CODE_DELAY_UNIT, 8'h01);
    host.wr(CODE_UT_RESP, 8'h42);
    rd_check(CODE_DELAY_UNIT, 8'h01);
    i_ut_fault = 1'b1;
    wait_out(1'b0, 100, n);
    check(n >= 16 && n <= 19, 1'b1);
    step(20);
    check(out_en, 1'b0);
    $display("test delay done");

    // Reset clears the latched fault and the response configuration byte.
    i_rst_n    = 1'b0;
    i_ut_fault = 1'b0;
    step(2);
    check(out_en, 1'b0);
    i_rst_n = 1'b1;
    wait_out(1'b1, 10, n);
    step(2);
    check(flag, 1'b0);
    rd_check(CODE_UT_RESP, CFG_RST);
    $display("test reset done");
    finish_test;
  end
endmodule
